// ---- inc/lofs_pkg.sv ----
package lofs_pkg;

  // ------------------------------------------------------------------
  // datapath widths and scaling
  // ------------------------------------------------------------------
  localparam int          LOFS_W          = 47;
  localparam int          LOFS_GAIN_SHIFT = 24;
  localparam logic signed [15:0] LOFS_FS         = 16'sh2710; // 10 V, also 100.00 %
  localparam logic signed [23:0] LOFS_NORM_MAX   = 24'sh3FFFFF;
  localparam logic [8:0]  LOFS_EXP_MIN    = 9'h001;
  localparam logic [8:0]  LOFS_EXP_MAX    = 9'h100;
  localparam logic [5:0]  LOFS_TC_MAX     = 6'h24;
  localparam logic [5:0]  LOFS_TC_FAST    = 6'h14;
  localparam logic [31:0] LOFS_SYNC_LIM   = 32'h00030D40; // 200 Hz in mHz
  localparam logic [16:0] LOFS_CORDIC_K   = 17'h09B75;
  localparam logic [3:0]  LOFS_ROT_LAST   = 4'hB;
  localparam logic signed [15:0] LOFS_PH_HALF    = 16'sh4650; // 180.00 deg
  localparam logic [11:0][15:0] LOFS_ATAN = {16'h0003, 16'h0006, 16'h000B, 16'h0016,
                                             16'h002D, 16'h005A, 16'h00B3, 16'h0166,
                                             16'h02C9, 16'h057C, 16'h0A61, 16'h1194};

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0]  LOFS_CTRL   = 8'h00;
  localparam logic [7:0]  LOFS_TCR    = 8'h04;
  localparam logic [7:0]  LOFS_SENS   = 8'h08;
  localparam logic [7:0]  LOFS_OFFX   = 8'h0C;
  localparam logic [7:0]  LOFS_OFFY   = 8'h10;
  localparam logic [7:0]  LOFS_OFFR   = 8'h14;
  localparam logic [7:0]  LOFS_EXPR   = 8'h18;
  localparam logic [7:0]  LOFS_SYNC   = 8'h1C;
  localparam logic [7:0]  LOFS_STAT   = 8'h20;
  localparam logic [1:0]  LOFS_OKAY   = 2'h0;
  localparam logic [1:0]  LOFS_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    LOFS_IDLE  = 4'b0001,
    LOFS_SCALE = 4'b0010,
    LOFS_ROT   = 4'b0100,
    LOFS_OUTP  = 4'b1000
  } lofs_fsm_e_t;

  typedef struct packed {
    logic [1:0][46:0] ch;   // 0 = in-phase, 1 = quadrature
  } lofs_sample_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] r;
    logic signed [15:0] phase;
  } lofs_disp_t;

  typedef struct packed {
    logic             sync_en;
    logic             ch1_sel;
    logic [5:0]       tc;
    logic [15:0]      sens_gain;
    logic [2:0][15:0] off;     // 0 = X, 1 = Y, 2 = R
    logic [8:0]       expand;
    logic [4:0]       sync_shift;
  } lofs_cfg_t;

  typedef struct packed {
    lofs_fsm_e_t      fsm;
    logic [3:0]       iter;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_full;
    logic             w_full;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    lofs_cfg_t        sw;
    lofs_cfg_t        act;
    logic             sync_act;
    logic             tc_lim;
    logic             overload;
    logic             tick_seen;
    logic [1:0][62:0] acc;
    logic [1:0][46:0] sync_v;
    logic [23:0]      nx;
    logic [23:0]      ny;
    logic [25:0]      cx;
    logic [25:0]      cy;
    logic [15:0]      cz;
    logic             in_ready;
    logic             out_valid;
    logic [15:0]      out1;
    logic [15:0]      out2;
    lofs_disp_t       disp;
  } lofs_st_t;

  typedef struct packed {
    logic signed [46:0] y;
  } lofs_lpf_st_t;

endpackage : lofs_pkg

// ---- logic/lofs_lpf.sv ----
`timescale 1ns/1ns
module lofs_lpf (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              en,
  input  wire logic [5:0]        shift,
  input  wire logic signed [46:0] din,
  output logic signed [46:0]     dout
);

  lofs_pkg::lofs_lpf_st_t s;
  lofs_pkg::lofs_lpf_st_t next_s;
  logic signed [47:0]     diff;
  logic signed [47:0]     sum;

  // ------------------------------------------------------------------
  // one-pole section, dc gain exactly one
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    diff   = {din[46], din} - {s.y[46], s.y};
    sum    = {s.y[46], s.y} + (diff >>> shift);
    if (en) begin
      next_s.y = sum[46:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.y;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  unity_gain_a: assert property (en && shift == 6'h00 |=> dout == $past(din))
    else $error("filter section does not pass input at unit gain");
  filter_hold_a: assert property (!en |=> $stable(dout))
    else $error("filter section moved without a sample");

endmodule : lofs_lpf

// ---- logic/lofs_filter_scaling.sv ----
`timescale 1ns/1ns
module lofs_filter_scaling (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire lofs_pkg::lofs_sample_t in_sample,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire logic [31:0]         ref_freq,
  input  wire logic                ref_tick,
  output logic signed [15:0]       first_analog_output,
  output logic signed [15:0]       second_analog_output,
  output lofs_pkg::lofs_disp_t     display,
  output logic                     out_valid
);

  lofs_pkg::lofs_st_t s;
  lofs_pkg::lofs_st_t next_s;
  logic               take;
  logic               do_write;
  logic               ref_low;
  logic [5:0]         tc_eff;
  logic               sync_on;
  logic [31:0]        wmask;
  logic [31:0]        wval;
  logic signed [23:0] norm_x;
  logic signed [23:0] norm_y;
  logic signed [42:0] r_prod;
  logic [2:0][34:0]   scaled;
  logic signed [46:0] a_out [2];
  logic signed [46:0] b_in  [2];
  logic signed [46:0] b_out [2];
  logic signed [46:0] c_out [2];

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rd_word(input lofs_pkg::lofs_st_t st, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case ({a[7:2], 2'h0})
      lofs_pkg::LOFS_CTRL: v[1:0]  = {st.sw.ch1_sel, st.sw.sync_en};
      lofs_pkg::LOFS_TCR:  v[5:0]  = st.sw.tc;
      lofs_pkg::LOFS_SENS: v[15:0] = st.sw.sens_gain;
      lofs_pkg::LOFS_OFFX: v       = 32'($signed(st.sw.off[0]));
      lofs_pkg::LOFS_OFFY: v       = 32'($signed(st.sw.off[1]));
      lofs_pkg::LOFS_OFFR: v       = 32'($signed(st.sw.off[2]));
      lofs_pkg::LOFS_EXPR: v[8:0]  = st.sw.expand;
      lofs_pkg::LOFS_SYNC: v[4:0]  = st.sw.sync_shift;
      lofs_pkg::LOFS_STAT: v[3:0]  = {st.in_ready, st.overload, st.tc_lim, st.sync_act};
      default:             v       = 32'h0;
    endcase
    return v;
  endfunction : rd_word

  function automatic logic known_addr(input logic [7:0] a);
    return {a[7:2], 2'h0} <= lofs_pkg::LOFS_STAT;
  endfunction : known_addr

  function automatic logic [15:0] clamp_off(input logic signed [15:0] v);
    if (v > lofs_pkg::LOFS_FS) begin
      return lofs_pkg::LOFS_FS;
    end else if (v < -lofs_pkg::LOFS_FS) begin
      return -lofs_pkg::LOFS_FS;
    end
    return v;
  endfunction : clamp_off

  function automatic logic signed [23:0] norm(input logic signed [46:0] f,
                                              input logic [15:0] g);
    logic signed [63:0] p;
    p = (64'(f) * $signed({48'h0, g})) >>> lofs_pkg::LOFS_GAIN_SHIFT;
    if (p > 64'(lofs_pkg::LOFS_NORM_MAX)) begin
      return lofs_pkg::LOFS_NORM_MAX;
    end else if (p < -64'(lofs_pkg::LOFS_NORM_MAX)) begin
      return -lofs_pkg::LOFS_NORM_MAX;
    end
    return p[23:0];
  endfunction : norm

  function automatic logic signed [15:0] sat16(input logic signed [34:0] p);
    if (p > 35'(lofs_pkg::LOFS_FS)) begin
      return lofs_pkg::LOFS_FS;
    end else if (p < -35'(lofs_pkg::LOFS_FS)) begin
      return -lofs_pkg::LOFS_FS;
    end
    return p[15:0];
  endfunction : sat16

  // ------------------------------------------------------------------
  // filter chain per channel: stage a, sync or bypass, stages b and c
  // ------------------------------------------------------------------
  assign take    = in_valid && s.in_ready;
  assign ref_low = ref_freq < lofs_pkg::LOFS_SYNC_LIM;
  assign sync_on = s.sw.sync_en && ref_low;
  // shift k gives tc = 2^k samples = 1/(2 pi fc) of each section
  assign tc_eff  = (!ref_low && s.sw.tc > lofs_pkg::LOFS_TC_FAST) ?
                   lofs_pkg::LOFS_TC_FAST : s.sw.tc;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign b_in[c] = sync_on ? $signed(s.sync_v[c]) : a_out[c];
    lofs_lpf u_a (.clock(clock), .rst(rst), .en(take), .shift(tc_eff),
                  .din($signed(in_sample.ch[c])), .dout(a_out[c]));
    lofs_lpf u_b (.clock(clock), .rst(rst), .en(take), .shift(tc_eff),
                  .din(b_in[c]), .dout(b_out[c]));
    lofs_lpf u_c (.clock(clock), .rst(rst), .en(take), .shift(tc_eff),
                  .din(b_out[c]), .dout(c_out[c]));
  end

  // ------------------------------------------------------------------
  // combinational datapath terms
  // ------------------------------------------------------------------
  assign do_write = s.aw_full && s.w_full && !s.bvalid;
  assign wmask    = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
  assign wval     = (rd_word(s, s.awaddr) & ~wmask) | (s.wdata & wmask);
  assign norm_x   = norm(c_out[0], s.act.sens_gain);
  assign norm_y   = norm(c_out[1], s.act.sens_gain);
  assign r_prod   = 43'($signed(s.cx)) * $signed({26'h0, lofs_pkg::LOFS_CORDIC_K});

  for (genvar k = 0; k < 3; k++) begin : g_out
    logic signed [23:0] v;
    assign v = (k == 0) ? $signed(s.nx) : (k == 1) ? $signed(s.ny) : r_prod[39:16];
    // (signal/sens + offset) x expand, code 10000 = 10 V
    assign scaled[k] = (35'(v) + 35'($signed(s.act.off[k]))) * $signed({26'h0, s.act.expand});
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.out_valid = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = known_addr(s.awaddr) ? lofs_pkg::LOFS_OKAY : lofs_pkg::LOFS_SLVERR;
      unique case ({s.awaddr[7:2], 2'h0})
        lofs_pkg::LOFS_CTRL: {next_s.sw.ch1_sel, next_s.sw.sync_en} = wval[1:0];
        lofs_pkg::LOFS_TCR:  next_s.sw.tc = (wval[5:0] > lofs_pkg::LOFS_TC_MAX) ?
                                           lofs_pkg::LOFS_TC_MAX : wval[5:0];
        lofs_pkg::LOFS_SENS: next_s.sw.sens_gain = wval[15:0];
        lofs_pkg::LOFS_OFFX: next_s.sw.off[0] = clamp_off(wval[15:0]);
        lofs_pkg::LOFS_OFFY: next_s.sw.off[1] = clamp_off(wval[15:0]);
        lofs_pkg::LOFS_OFFR: next_s.sw.off[2] = clamp_off(wval[15:0]);
        lofs_pkg::LOFS_EXPR: next_s.sw.expand =
                                (wval[8:0] < lofs_pkg::LOFS_EXP_MIN) ? lofs_pkg::LOFS_EXP_MIN :
                                (wval[8:0] > lofs_pkg::LOFS_EXP_MAX) ? lofs_pkg::LOFS_EXP_MAX :
                                wval[8:0];
        lofs_pkg::LOFS_SYNC: next_s.sw.sync_shift = wval[4:0];
        default: ;
      endcase
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word(s, s_axi_araddr);
      next_s.rresp  = known_addr(s_axi_araddr) ? lofs_pkg::LOFS_OKAY : lofs_pkg::LOFS_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
    next_s.tick_seen = s.tick_seen || ref_tick;

    unique case (s.fsm)
      lofs_pkg::LOFS_IDLE: begin
        next_s.in_ready = 1'b1;
        if (take) begin
          next_s.act      = s.sw;
          next_s.act.tc   = tc_eff;
          next_s.tc_lim   = tc_eff != s.sw.tc;
          next_s.sync_act = sync_on;
          next_s.tick_seen = 1'b0;
          for (int c = 0; c < 2; c++) begin
            if (s.tick_seen || ref_tick) begin
              next_s.sync_v[c] = 47'(($signed(s.acc[c]) + 63'(a_out[c])) >>> s.sw.sync_shift);
              next_s.acc[c]    = 63'h0;
            end else begin
              next_s.acc[c] = $signed(s.acc[c]) + 63'(a_out[c]);
            end
          end
          next_s.in_ready = 1'b0;
          next_s.fsm      = lofs_pkg::LOFS_SCALE;
        end
      end
      lofs_pkg::LOFS_SCALE: begin
        next_s.nx   = norm_x;
        next_s.ny   = norm_y;
        next_s.iter = 4'h0;
        // fold left half-plane onto the right before vectoring
        if (norm_x < 0) begin
          next_s.cx = -26'(norm_x);
          next_s.cy = -26'(norm_y);
          next_s.cz = (norm_y < 0) ? -lofs_pkg::LOFS_PH_HALF : lofs_pkg::LOFS_PH_HALF;
        end else begin
          next_s.cx = 26'(norm_x);
          next_s.cy = 26'(norm_y);
          next_s.cz = 16'h0;
        end
        next_s.fsm = lofs_pkg::LOFS_ROT;
      end
      lofs_pkg::LOFS_ROT: begin
        if ($signed(s.cy) >= 0) begin
          next_s.cx = $signed(s.cx) + ($signed(s.cy) >>> s.iter);
          next_s.cy = $signed(s.cy) - ($signed(s.cx) >>> s.iter);
          next_s.cz = s.cz + lofs_pkg::LOFS_ATAN[s.iter];
        end else begin
          next_s.cx = $signed(s.cx) - ($signed(s.cy) >>> s.iter);
          next_s.cy = $signed(s.cy) + ($signed(s.cx) >>> s.iter);
          next_s.cz = s.cz - lofs_pkg::LOFS_ATAN[s.iter];
        end
        next_s.iter = s.iter + 4'h1;
        if (s.iter == lofs_pkg::LOFS_ROT_LAST) begin
          next_s.fsm = lofs_pkg::LOFS_OUTP;
        end
      end
      lofs_pkg::LOFS_OUTP: begin
        next_s.disp.x     = sat16(scaled[0]);
        next_s.disp.y     = sat16(scaled[1]);
        next_s.disp.r     = sat16(scaled[2]);
        next_s.disp.phase = s.cz;
        next_s.out1       = s.act.ch1_sel ? sat16(scaled[2]) : sat16(scaled[0]);
        next_s.out2       = sat16(scaled[1]);
        next_s.overload   = 1'b0;
        for (int k = 0; k < 3; k++) begin
          if (sat16(scaled[k]) != scaled[k][15:0] ||
              $signed(scaled[k]) != 35'($signed(scaled[k][15:0]))) begin
            next_s.overload = 1'b1;
          end
        end
        next_s.out_valid = 1'b1;
        next_s.in_ready  = 1'b1;
        next_s.fsm       = lofs_pkg::LOFS_IDLE;
      end
      default: begin
        next_s.fsm = lofs_pkg::LOFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s               <= '0;
      s.fsm           <= lofs_pkg::LOFS_IDLE;
      s.awready       <= 1'b1;
      s.wready        <= 1'b1;
      s.arready       <= 1'b1;
      s.sw.expand     <= lofs_pkg::LOFS_EXP_MIN;
      s.act.expand    <= lofs_pkg::LOFS_EXP_MIN;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign s_axi_awready        = s.awready;
  assign s_axi_wready         = s.wready;
  assign s_axi_bvalid         = s.bvalid;
  assign s_axi_bresp          = s.bresp;
  assign s_axi_arready        = s.arready;
  assign s_axi_rvalid         = s.rvalid;
  assign s_axi_rdata          = s.rdata;
  assign s_axi_rresp          = s.rresp;
  assign in_ready             = s.in_ready;
  assign out_valid            = s.out_valid;
  assign first_analog_output  = s.out1;
  assign second_analog_output = s.out2;
  assign display              = s.disp;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_walk;
    s.fsm == lofs_pkg::LOFS_SCALE ##1 (s.fsm == lofs_pkg::LOFS_ROT)[*8]
      ##5 s.fsm == lofs_pkg::LOFS_OUTP ##1 out_valid;
  endsequence

  sample_walk_a: assert property (s_take |-> ##1 s_walk)
    else $error("sample did not finish in fixed latency");
  cfg_hold_a: assert property (!in_ready |=> $stable(s.act))
    else $error("active settings changed mid-sample");
  sync_gate_a: assert property (s_take |=> s.sync_act == $past(s.sw.sync_en && ref_low))
    else $error("synchronous stage gate wrong");
  tc_limit_a: assert property ((s_take and !ref_low) |=> s.act.tc <= lofs_pkg::LOFS_TC_FAST)
    else $error("long time constant above 200 Hz");
  off_range_a: assert property ($signed(s.sw.off[0]) <= lofs_pkg::LOFS_FS &&
                                $signed(s.sw.off[2]) >= -lofs_pkg::LOFS_FS)
    else $error("offset beyond full scale");
  expand_range_a: assert property (s.sw.expand >= lofs_pkg::LOFS_EXP_MIN &&
                                   s.sw.expand <= lofs_pkg::LOFS_EXP_MAX)
    else $error("expand out of range");
  sens_keep_a: assert property (do_write && s.awaddr[7:2] == lofs_pkg::LOFS_SENS[7:2]
                                |=> $stable(s.sw.off))
    else $error("offset moved on sensitivity write");
  gain_only_a: assert property (s.fsm == lofs_pkg::LOFS_SCALE && c_out[0] == 47'h0
                                |=> s.nx == 24'h0)
    else $error("dc gain adds an offset");
  out_sat_a: assert property (s.fsm == lofs_pkg::LOFS_OUTP &&
                              $signed(scaled[0]) > 35'(lofs_pkg::LOFS_FS)
                              |=> display.x == lofs_pkg::LOFS_FS && s.overload)
    else $error("overrange did not saturate");
  out_clamp_a: assert property (out_valid |-> $signed(first_analog_output) <= lofs_pkg::LOFS_FS
                                && $signed(second_analog_output) >= -lofs_pkg::LOFS_FS)
    else $error("analog output beyond 10 V");

endmodule : lofs_filter_scaling

// ---- testbench/lofs_src.sv ----
`timescale 1ns/1ns
module lofs_src (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   go,
  input  wire logic signed [46:0]     x_val,
  input  wire logic signed [46:0]     y_val,
  input  wire logic                   in_ready,
  output lofs_pkg::lofs_sample_t      in_sample,
  output logic                        in_valid
);
  // held until taken, then scrambled so stale data is never reused
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_valid  <= 1'b0;
      in_sample <= '0;
    end else if (in_valid && in_ready) begin
      in_valid  <= 1'b0;
      in_sample <= ~in_sample;
    end else if (go && !in_valid) begin
      in_valid     <= 1'b1;
      in_sample.ch <= {y_val, x_val};
    end
  end
endmodule : lofs_src

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic        clock = 1'b0, rst = 1'b1, go = 1'b0, ref_tick = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, ref_freq = 32'h000F4240, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        in_valid, in_ready, out_valid;
  logic signed [15:0] o1, o2;
  logic signed [46:0] xv = '0, yv = '0;
  lofs_pkg::lofs_sample_t in_sample;
  lofs_pkg::lofs_disp_t   display;
  int          n_errors = 0, checks = 0;
  always #5 clock = ~clock;
  lofs_filter_scaling uut (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_sample(in_sample), .in_valid(in_valid),
    .in_ready(in_ready), .ref_freq(ref_freq), .ref_tick(ref_tick), .first_analog_output(o1),
    .second_analog_output(o2), .display(display), .out_valid(out_valid));
  lofs_src src (.clock(clock), .rst(rst), .go(go), .x_val(xv), .y_val(yv),
    .in_ready(in_ready), .in_sample(in_sample), .in_valid(in_valid));
  // ------------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_near(input logic signed [31:0] got, input logic signed [31:0] exp,
                          input logic signed [31:0] tol);
    checks++;
    if ((got - exp <= tol && exp - got <= tol) !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic send(input int k, input logic signed [46:0] x, input logic signed [46:0] y);
    int t;
    xv <= x;
    yv <= y;
    repeat (k) begin
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      t = 0;
      do begin
        @(posedge clock);
        t++;
      end while (!out_valid && t < 40);
      chk({31'h0, out_valid}, 32'h1);
    end
  endtask : send
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h18, 32'h1, 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    wr(8'h28, 32'h1);
    chk({30'h0, rs}, 32'h2);
    wr(8'h0C, 32'h00004E20);
    rd(8'h0C, 32'h00002710, 2'h0);
    wr(8'h0C, 32'hFFFFB1E0);
    rd(8'h0C, 32'hFFFFD8F0, 2'h0);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h1, 2'h0);
    wr(8'h18, 32'h12C);
    rd(8'h18, 32'h100, 2'h0);
  endtask : t_regs
  task automatic t_offs;
    wr(8'h0C, 32'h64);
    wr(8'h10, 32'hFFFFEC78);
    wr(8'h14, 32'h7);
    wr(8'h18, 32'h3);
    send(1, 47'sd12345, 47'sd999);
    chk({16'h0, o1}, 32'h012C);
    chk({16'h0, o2}, 32'hD8F0);
    chk({16'h0, display.r}, 32'h0015);
  endtask : t_offs
  task automatic t_gain;
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h1);
    wr(8'h08, 32'h100);
    send(5, 47'sd6553600, -47'sd3276800);
    chk({16'h0, o1}, 32'h0064);
    chk({16'h0, o2}, 32'hFFCE);
    wr(8'h0C, 32'h64);
    wr(8'h08, 32'h200);
    rd(8'h0C, 32'h64, 2'h0);
    send(1, 47'sd6553600, -47'sd3276800);
    chk({16'h0, o1}, 32'h012C);
    chk({16'h0, display.y}, 32'hFF9C);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h28);
    rd(8'h04, 32'h24, 2'h0);
    send(1, 47'sd6553600, -47'sd3276800);
    rd(8'h20, 32'hA, 2'h0);
  endtask : t_gain
  task automatic t_sync;
    ref_freq <= 32'h000186A0;
    ref_tick <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h3);
    send(5, 47'sd163840000, 47'sd0);
    chk({16'h0, display.x}, 32'h1388);
    chk({16'h0, o2}, 32'h0);
    chk_near(32'(o1), 32'sh1388, 32'sh32);
    chk_near(32'(display.phase), 32'sh0, 32'sh14);
    rd(8'h20, 32'h9, 2'h0);
    wr(8'h18, 32'h3);
    send(1, 47'sd163840000, 47'sd0);
    chk({16'h0, display.x}, 32'h2710);
    chk({16'h0, o1}, 32'h2710);
    rd(8'h20, 32'hD, 2'h0);
    ref_tick <= 1'b0;
  endtask : t_sync
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_offs();
    t_gain();
    t_sync();
    stop_test();
  end
endmodule : tb_top
